// ==== verilog/ica_pkg.sv ====
package ica_pkg;
  // Clock and timebases
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned TENTH_US_NS = 100;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TENTH_CYCLES = (TENTH_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned US_CNT_W = 7;
  localparam int unsigned TENTH_CNT_W = 4;
  localparam int unsigned MS_CNT_W = 17;
  // Input rate limits for width and frequency
  localparam int unsigned MAX_WIDTH_RATE_HZ = 10000;
  localparam int unsigned MAX_FREQ_RATE_HZ = 20000;
  // Sizes
  localparam int unsigned NUM_IN = 12;
  localparam int unsigned NUM_MEAS = 6;
  localparam int unsigned NUM_PAIRS = 3;
  localparam int unsigned NUM_SRC = 13;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MEM_DEPTH = 12;
  localparam int unsigned MEM_AW = 4;
  localparam int unsigned PERIOD_MS_W = 16;
  localparam int unsigned DIV_CNT_W = 6;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  // Command codes
  localparam logic [7:0] OPT_TENTH_US = 8'h14;
  localparam logic [7:0] OPT_ON = 8'h01;
  localparam logic [4:0] SRC_PERIODIC = 5'h12;
  localparam logic [1:0] KIND_WIDTH = 2'h0;
  localparam logic [1:0] KIND_FREQ = 2'h1;
  localparam logic [1:0] KIND_PERIOD = 2'h2;
  localparam logic [31:0] UNITS_PER_S_US = 32'h000f4240;
  localparam logic [31:0] UNITS_PER_S_TENTH = 32'h00989680;
  localparam logic [2:0] TENTH_LAST_CH = 3'h4;
  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_WAIT = 2'b01,
    Q_READ = 2'b10,
    Q_DIV = 2'b11
  } ica_qstate_t;
endpackage

// ==== verilog/ica_result_mem.sv ====
`timescale 1ns/1ps
module ica_result_mem (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Write side, one enable per entry
  input wire logic [ica_pkg::MEM_DEPTH-1:0] i_we,
  input wire logic [ica_pkg::MEM_DEPTH*ica_pkg::DATA_W-1:0] i_wdata,
  // Read side
  input wire logic [ica_pkg::MEM_AW-1:0] i_raddr,
  output logic [ica_pkg::DATA_W-1:0] o_rdata
);
  logic [ica_pkg::DATA_W-1:0] mem_ff [ica_pkg::MEM_DEPTH];

  // Each entry keeps its last complete value
  for (genvar g = 0; g < ica_pkg::MEM_DEPTH; g++) begin : g_ent
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        mem_ff[g] <= '0;
      end else if (i_we[g]) begin
        mem_ff[g] <= i_wdata[g*ica_pkg::DATA_W +: ica_pkg::DATA_W]; // RQ25
      end
    end
  end

  // Registered read, zero beyond the last entry
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_raddr < ica_pkg::MEM_AW'(ica_pkg::MEM_DEPTH)) begin
      o_rdata <= mem_ff[i_raddr];
    end else begin
      o_rdata <= '0;
    end
  end
endmodule // ica_result_mem

// ==== verilog/ica_pulse_meas.sv ====
`timescale 1ns/1ps
module ica_pulse_meas (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_en,
  input wire logic i_restart,
  input wire logic i_tick,
  // Pulse input
  input wire logic i_din,
  // Results
  output logic o_width_we,
  output logic [ica_pkg::DATA_W-1:0] o_width,
  output logic o_period_we,
  output logic [ica_pkg::DATA_W-1:0] o_period
);
  logic din_q_ff;
  logic seen_rise_ff;
  logic high_ff;
  logic [ica_pkg::DATA_W-1:0] width_cnt_ff;
  logic [ica_pkg::DATA_W-1:0] period_cnt_ff;
  logic rise;
  logic fall;

  assign rise = i_din & ~din_q_ff;
  assign fall = ~i_din & din_q_ff;

  // Previous input level
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      din_q_ff <= 1'b0;
    end else begin
      din_q_ff <= i_din;
    end
  end

  // Period: rising edge to rising edge, in timebase ticks
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      seen_rise_ff <= 1'b0;
      period_cnt_ff <= '0;
      o_period_we <= 1'b0;
      o_period <= '0;
    end else begin
      o_period_we <= 1'b0;
      if (!i_en || i_restart) begin
        seen_rise_ff <= 1'b0;
        period_cnt_ff <= '0;
      end else if (rise) begin
        seen_rise_ff <= 1'b1;
        period_cnt_ff <= '0;
        if (seen_rise_ff) begin
          o_period_we <= 1'b1; // RQ25
          o_period <= period_cnt_ff;
        end
      end else if (i_tick && !(&period_cnt_ff)) begin
        period_cnt_ff <= period_cnt_ff + 1'b1; // RQ6
      end
    end
  end

  // Width: length of the high part of each pulse
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      high_ff <= 1'b0;
      width_cnt_ff <= '0;
      o_width_we <= 1'b0;
      o_width <= '0;
    end else begin
      o_width_we <= 1'b0;
      if (!i_en || i_restart) begin
        high_ff <= 1'b0;
        width_cnt_ff <= '0;
      end else if (rise) begin
        high_ff <= 1'b1; // RQ23
        width_cnt_ff <= '0;
      end else if (fall && high_ff) begin
        high_ff <= 1'b0;
        o_width_we <= 1'b1; // RQ25
        o_width <= width_cnt_ff; // RQ23
      end else if (i_tick && high_ff && !(&width_cnt_ff)) begin
        width_cnt_ff <= width_cnt_ff + 1'b1;
      end
    end
  end
endmodule // ica_pulse_meas

// ==== verilog/ica_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Core enables measurement once per channel
// RQ2 - Width, frequency, period readable per channel
// RQ3 - Period is reciprocal of reported frequency
// RQ4 - Reset default: microsecond units everywhere
// RQ5 - Option 20 gives tenths on channels 1-4
// RQ6 - Width to 10 kHz, frequency to 20 kHz
// RQ7 - Counting and measuring coexist on one input
// RQ8 - Counter define also enables pair measurement
// RQ9 - Measure enable alone leaves counter off
// RQ10 - Measure enable after counter disables counter
// RQ11 - Interrupts are edge detected, short levels caught
// RQ12 - Interrupt sources: inputs 1-6, 9-12
// RQ13 - Each interrupt picks rising or falling
// RQ14 - Configured edge starts routine at once
// RQ15 - Interrupt inputs lose counter and measurement
// RQ16 - Inputs 9-12 plain or interrupt only
// RQ17 - Source 18 is periodic millisecond timer
// RQ18 - Periodic timer independent of program scan
// RQ19 - Periodic expiry pre-empts normal work immediately
// RQ20 - Periodic waits for running routine; no nesting
// RQ21 - Software keeps routines short, loop free
// RQ22 - Measurement channel n uses input n
// RQ23 - Width is the high part of pulse
// RQ24 - Pending edges served singly by priority
// RQ25 - Results update per completed pulse, then hold
module ica_top #(
  parameter int unsigned P_MS_CYCLES = ica_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Digital inputs 1 to 12
  input wire logic [ica_pkg::NUM_IN-1:0] i_din,
  // Measurement enable command
  input wire logic i_meas_en_stb,
  input wire logic [2:0] i_meas_en_ch,
  // Counter define command
  input wire logic i_cnt_def_stb,
  input wire logic [1:0] i_cnt_def_pair,
  // System option command
  input wire logic i_sysopt_stb,
  input wire logic [7:0] i_sysopt_num,
  input wire logic [7:0] i_sysopt_val,
  // Interrupt define command
  input wire logic i_intr_def_stb,
  input wire logic [4:0] i_intr_def_src,
  input wire logic i_intr_def_falling,
  input wire logic [ica_pkg::PERIOD_MS_W-1:0] i_intr_def_period_ms,
  // Service routine handshake
  input wire logic i_svc_done,
  output logic o_svc_start,
  output logic [4:0] o_svc_src,
  output logic o_svc_active,
  // Result queries
  input wire logic i_query_stb,
  input wire logic [2:0] i_query_ch,
  input wire logic [1:0] i_query_kind,
  output logic o_query_busy,
  output logic o_query_valid,
  output logic [ica_pkg::DATA_W-1:0] o_query_data,
  // Pin ownership and mode status
  output logic [ica_pkg::NUM_MEAS-1:0] o_meas_en,
  output logic [ica_pkg::NUM_PAIRS-1:0] o_cnt_en,
  output logic [ica_pkg::NUM_IN-1:0] o_intr_en,
  output logic o_periodic_en,
  output logic o_tenth_mode
);
  logic [ica_pkg::NUM_IN-1:0] in_q_ff;
  logic [ica_pkg::NUM_IN-1:0] intr_fall_ff;
  logic [ica_pkg::PERIOD_MS_W-1:0] period_ms_ff;
  logic [ica_pkg::PERIOD_MS_W-1:0] per_cnt_ff;
  logic [ica_pkg::US_CNT_W-1:0] us_cnt_ff;
  logic [ica_pkg::TENTH_CNT_W-1:0] tenth_cnt_ff;
  logic [ica_pkg::MS_CNT_W-1:0] ms_cnt_ff;
  logic us_tick_ff;
  logic tenth_tick_ff;
  logic ms_tick_ff;
  logic per_evt_ff;
  logic restart_ff;
  logic [ica_pkg::NUM_SRC-1:0] pend_ff;
  logic [ica_pkg::NUM_SRC-1:0] grant;
  logic [4:0] grant_src;
  logic [ica_pkg::NUM_IN-1:0] edge_hit;
  logic [2:0] meas_idx;
  logic [3:0] isrc_idx;
  logic isrc_shared;
  logic isrc_plain;
  logic periodic_def;
  ica_pkg::ica_qstate_t q_state_ff;
  logic [ica_pkg::MEM_AW-1:0] q_addr_ff;
  logic q_bad_ff;
  logic [1:0] q_kind_ff;
  logic q_tenth_ff;
  logic [32:0] rem_ff;
  logic [ica_pkg::DATA_W-1:0] quo_ff;
  logic [ica_pkg::DATA_W-1:0] div_ff;
  logic [ica_pkg::DIV_CNT_W-1:0] div_cnt_ff;
  logic [32:0] rem_sh;
  logic div_ge;
  logic [ica_pkg::DATA_W-1:0] rdata;
  logic [ica_pkg::MEM_DEPTH-1:0] mem_we;
  logic [ica_pkg::MEM_DEPTH*ica_pkg::DATA_W-1:0] mem_wdata;

  // Command decode
  assign meas_idx = 3'(i_meas_en_ch - 3'h1);
  assign isrc_idx = 4'(i_intr_def_src - 5'h01);
  assign isrc_shared = (i_intr_def_src >= 5'h01) && (i_intr_def_src <= 5'h06); // RQ12
  assign isrc_plain = (i_intr_def_src >= 5'h09) && (i_intr_def_src <= 5'h0c); // RQ12
  assign periodic_def = i_intr_def_stb && (i_intr_def_src == ica_pkg::SRC_PERIODIC); // RQ17

  // Pin ownership among counter, measurement and interrupt
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_meas_en <= '0;
      o_cnt_en <= '0;
      o_intr_en <= '0;
      intr_fall_ff <= '0;
    end else if (i_meas_en_stb && (i_meas_en_ch >= 3'h1) && (i_meas_en_ch <= 3'h6)) begin
      o_meas_en[meas_idx] <= 1'b1; // RQ9
      o_cnt_en[meas_idx[2:1]] <= 1'b0; // RQ10
      o_intr_en[meas_idx] <= 1'b0;
    end else if (i_cnt_def_stb && (i_cnt_def_pair < 2'h3)) begin
      o_cnt_en[i_cnt_def_pair] <= 1'b1; // RQ7
      o_meas_en[{i_cnt_def_pair, 1'b0}] <= 1'b1; // RQ8
      o_meas_en[{i_cnt_def_pair, 1'b1}] <= 1'b1; // RQ8
      o_intr_en[{i_cnt_def_pair, 1'b0}] <= 1'b0;
      o_intr_en[{i_cnt_def_pair, 1'b1}] <= 1'b0;
    end else if (i_intr_def_stb && isrc_shared) begin
      o_intr_en[isrc_idx] <= 1'b1;
      intr_fall_ff[isrc_idx] <= i_intr_def_falling; // RQ13
      o_meas_en[isrc_idx[2:0]] <= 1'b0; // RQ15
      o_cnt_en[isrc_idx[2:1]] <= 1'b0; // RQ15
    end else if (i_intr_def_stb && isrc_plain) begin
      o_intr_en[isrc_idx] <= 1'b1; // RQ16
      intr_fall_ff[isrc_idx] <= i_intr_def_falling; // RQ13
    end
  end

  // Periodic timer setup
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_periodic_en <= 1'b0;
      period_ms_ff <= '0;
    end else if (periodic_def) begin
      o_periodic_en <= (i_intr_def_period_ms != '0); // RQ17
      period_ms_ff <= i_intr_def_period_ms;
    end
  end

  // Unit option; measurements restart when it is written
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tenth_mode <= 1'b0; // RQ4
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= 1'b0;
      if (i_sysopt_stb && (i_sysopt_num == ica_pkg::OPT_TENTH_US)) begin
        o_tenth_mode <= (i_sysopt_val == ica_pkg::OPT_ON); // RQ5
        restart_ff <= 1'b1;
      end
    end
  end

  // Timebase dividers: microsecond and tenth enables
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      us_cnt_ff <= '0;
      tenth_cnt_ff <= '0;
      us_tick_ff <= 1'b0;
      tenth_tick_ff <= 1'b0;
    end else begin
      us_tick_ff <= (us_cnt_ff == ica_pkg::US_CNT_W'(ica_pkg::US_CYCLES - 1));
      tenth_tick_ff <= (tenth_cnt_ff == ica_pkg::TENTH_CNT_W'(ica_pkg::TENTH_CYCLES - 1));
      if (us_cnt_ff == ica_pkg::US_CNT_W'(ica_pkg::US_CYCLES - 1)) begin
        us_cnt_ff <= '0;
      end else begin
        us_cnt_ff <= us_cnt_ff + 1'b1;
      end
      if (tenth_cnt_ff == ica_pkg::TENTH_CNT_W'(ica_pkg::TENTH_CYCLES - 1)) begin
        tenth_cnt_ff <= '0;
      end else begin
        tenth_cnt_ff <= tenth_cnt_ff + 1'b1;
      end
    end
  end

  // Millisecond prescaler, realigned when the timer is defined
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ms_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
    end else if (periodic_def) begin
      ms_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= (ms_cnt_ff == ica_pkg::MS_CNT_W'(P_MS_CYCLES - 1));
      if (ms_cnt_ff == ica_pkg::MS_CNT_W'(P_MS_CYCLES - 1)) begin
        ms_cnt_ff <= '0;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 1'b1; // RQ18
      end
    end
  end

  // Periodic event every period_ms milliseconds
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      per_cnt_ff <= '0;
      per_evt_ff <= 1'b0;
    end else begin
      per_evt_ff <= 1'b0;
      if (periodic_def || !o_periodic_en) begin
        per_cnt_ff <= '0;
      end else if (ms_tick_ff) begin
        if (per_cnt_ff == period_ms_ff - 1'b1) begin
          per_cnt_ff <= '0;
          per_evt_ff <= 1'b1; // RQ17
        end else begin
          per_cnt_ff <= per_cnt_ff + 1'b1; // RQ18
        end
      end
    end
  end

  // Input edge detection
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      in_q_ff <= '0;
    end else begin
      in_q_ff <= i_din;
    end
  end
  assign edge_hit = o_intr_en & ((i_din & ~in_q_ff & ~intr_fall_ff) | (~i_din & in_q_ff & intr_fall_ff)); // RQ11

  // Pending sources; a new edge wins over the clear of its grant
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~grant & {o_periodic_en, o_intr_en}) | {per_evt_ff, edge_hit}; // RQ24
    end
  end

  // Fixed priority grant: periodic first, then input 1 upward
  always_comb begin
    grant = '0;
    grant_src = '0;
    if (!o_svc_active) begin // RQ20
      for (int i = ica_pkg::NUM_IN - 1; i >= 0; i--) begin
        if (pend_ff[i]) begin
          grant = ica_pkg::NUM_SRC'(1) << i; // RQ24
          grant_src = 5'(i + 1);
        end
      end
      if (pend_ff[ica_pkg::NUM_SRC-1]) begin
        grant = ica_pkg::NUM_SRC'(1) << (ica_pkg::NUM_SRC - 1); // RQ19
        grant_src = ica_pkg::SRC_PERIODIC;
      end
    end
  end

  // Service routine start and busy flag, no nesting
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_svc_start <= 1'b0;
      o_svc_src <= '0;
      o_svc_active <= 1'b0;
    end else begin
      o_svc_start <= |grant; // RQ14
      if (|grant) begin
        o_svc_src <= grant_src;
        o_svc_active <= 1'b1; // RQ20
      end else if (i_svc_done) begin
        o_svc_active <= 1'b0;
      end
    end
  end

  // Measurement channels on inputs 1 to 6
  for (genvar c = 0; c < ica_pkg::NUM_MEAS; c++) begin : g_meas
    logic tick;
    assign tick = (o_tenth_mode && (c < ica_pkg::TENTH_LAST_CH)) ? tenth_tick_ff : us_tick_ff; // RQ5
    ica_pulse_meas u_meas (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_en(o_meas_en[c]),
      .i_restart(restart_ff),
      .i_tick(tick),
      .i_din(i_din[c]), // RQ22
      .o_width_we(mem_we[2*c]),
      .o_width(mem_wdata[2*c*ica_pkg::DATA_W +: ica_pkg::DATA_W]),
      .o_period_we(mem_we[2*c+1]),
      .o_period(mem_wdata[(2*c+1)*ica_pkg::DATA_W +: ica_pkg::DATA_W])
    );
  end

  // Result store
  ica_result_mem u_mem (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_we(mem_we),
    .i_wdata(mem_wdata),
    .i_raddr(q_addr_ff),
    .o_rdata(rdata)
  );

  // Divider step for frequency
  assign rem_sh = {rem_ff[31:0], quo_ff[31]};
  assign div_ge = (rem_sh >= {1'b0, div_ff});

  // Query sequencer with serial reciprocal
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q_state_ff <= ica_pkg::Q_IDLE;
      q_addr_ff <= '0;
      q_bad_ff <= 1'b0;
      q_kind_ff <= '0;
      q_tenth_ff <= 1'b0;
      rem_ff <= '0;
      quo_ff <= '0;
      div_ff <= '0;
      div_cnt_ff <= '0;
      o_query_busy <= 1'b0;
      o_query_valid <= 1'b0;
      o_query_data <= '0;
    end else begin
      o_query_valid <= 1'b0;
      case (q_state_ff)
        ica_pkg::Q_IDLE: begin
          if (i_query_stb) begin
            q_addr_ff <= {3'(i_query_ch - 3'h1), i_query_kind != ica_pkg::KIND_WIDTH}; // RQ2
            q_bad_ff <= (i_query_ch < 3'h1) || (i_query_ch > 3'h6) || (i_query_kind > ica_pkg::KIND_PERIOD);
            q_kind_ff <= i_query_kind;
            q_tenth_ff <= o_tenth_mode && (i_query_ch <= ica_pkg::TENTH_LAST_CH);
            o_query_busy <= 1'b1;
            q_state_ff <= ica_pkg::Q_WAIT;
          end
        end
        ica_pkg::Q_WAIT: begin
          q_state_ff <= ica_pkg::Q_READ;
        end
        ica_pkg::Q_READ: begin
          if (!q_bad_ff && (q_kind_ff == ica_pkg::KIND_FREQ) && (rdata != '0)) begin
            rem_ff <= '0;
            quo_ff <= q_tenth_ff ? ica_pkg::UNITS_PER_S_TENTH : ica_pkg::UNITS_PER_S_US; // RQ3
            div_ff <= rdata;
            div_cnt_ff <= '0;
            q_state_ff <= ica_pkg::Q_DIV;
          end else begin
            o_query_data <= (q_bad_ff || (q_kind_ff == ica_pkg::KIND_FREQ)) ? '0 : rdata; // RQ2
            o_query_valid <= 1'b1;
            o_query_busy <= 1'b0;
            q_state_ff <= ica_pkg::Q_IDLE;
          end
        end
        ica_pkg::Q_DIV: begin
          rem_ff <= div_ge ? (rem_sh - {1'b0, div_ff}) : rem_sh;
          quo_ff <= {quo_ff[30:0], div_ge}; // RQ3
          div_cnt_ff <= div_cnt_ff + 1'b1;
          if (div_cnt_ff == ica_pkg::DIV_STEPS - 1'b1) begin
            o_query_data <= {quo_ff[30:0], div_ge};
            o_query_valid <= 1'b1;
            o_query_busy <= 1'b0;
            q_state_ff <= ica_pkg::Q_IDLE;
          end
        end
        default: begin
          q_state_ff <= ica_pkg::Q_IDLE;
        end
      endcase
    end
  end
endmodule // ica_top

// ==== verif/ica_assertions.sv ====
`timescale 1ns/1ps
module ica_assertions (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Inputs of the block
  input wire logic i_meas_en_stb,
  input wire logic [2:0] i_meas_en_ch,
  input wire logic i_cnt_def_stb,
  input wire logic [1:0] i_cnt_def_pair,
  input wire logic i_sysopt_stb,
  input wire logic [7:0] i_sysopt_num,
  input wire logic [7:0] i_sysopt_val,
  input wire logic i_query_stb,
  input wire logic [1:0] i_query_kind,
  // Outputs of the block
  input wire logic o_svc_start,
  input wire logic [4:0] o_svc_src,
  input wire logic o_svc_active,
  input wire logic o_query_busy,
  input wire logic o_query_valid,
  input wire logic [ica_pkg::DATA_W-1:0] o_query_data,
  input wire logic [ica_pkg::NUM_MEAS-1:0] o_meas_en,
  input wire logic [ica_pkg::NUM_PAIRS-1:0] o_cnt_en,
  input wire logic [ica_pkg::NUM_IN-1:0] o_intr_en,
  input wire logic o_tenth_mode
);
  logic [2:0] m_idx;
  logic [2:0] p_lo;
  logic take;
  // Helper terms
  assign m_idx = i_meas_en_ch - 3'h1;
  assign p_lo = {i_cnt_def_pair, 1'b0};
  assign take = i_query_stb && !o_query_busy;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Query answer steps
  sequence s_busy;
    o_query_busy [*2];
  endsequence
  sequence s_answer;
    o_query_valid && !o_query_busy ##1 !o_query_valid;
  endsequence
  AST_QUERY_LAT: assert property (take && i_query_kind != ica_pkg::KIND_FREQ |=> s_busy ##1 s_answer)
    else $error("query answer timing");
  AST_FREQ_LAT: assert property (take && i_query_kind == ica_pkg::KIND_FREQ |-> ##[3:35] o_query_valid)
    else $error("frequency answer late");
  AST_DATA_HOLD: assert property (!o_query_valid |-> $stable(o_query_data))
    else $error("result changed without answer");
  AST_MEAS_OWN: assert property (i_meas_en_stb && i_meas_en_ch inside {[3'h1:3'h6]} |=>
    o_meas_en[$past(m_idx)] && !o_intr_en[$past(m_idx)] && !o_cnt_en[$past(m_idx) >> 1])
    else $error("measure enable ownership");
  AST_CNT_DEF: assert property (i_cnt_def_stb && i_cnt_def_pair != 2'h3 && !i_meas_en_stb |=>
    o_cnt_en[$past(i_cnt_def_pair)] && o_meas_en[$past(p_lo) +: 2] == 2'h3)
    else $error("counter define ownership");
  AST_INTR_EXCL: assert property ((o_intr_en[5:0] & o_meas_en) == 6'h0)
    else $error("interrupt and measurement share input");
  AST_INTR_RSVD: assert property (o_intr_en[7:6] == 2'h0)
    else $error("interrupt on inputs 7 or 8");
  AST_TENTH: assert property (i_sysopt_stb && i_sysopt_num == ica_pkg::OPT_TENTH_US |=>
    o_tenth_mode == ($past(i_sysopt_val) == ica_pkg::OPT_ON))
    else $error("tenth mode wrong");
  AST_SVC_ONE: assert property (o_svc_start |=> !o_svc_start)
    else $error("start longer than one cycle");
  AST_NO_NEST: assert property (o_svc_start |-> !$past(o_svc_active))
    else $error("routine started while active");
  AST_SVC_SRC: assert property (o_svc_start |-> o_svc_src inside {[5'h1:5'h6], [5'h9:5'hc], 5'h12})
    else $error("bad source number");
endmodule // ica_assertions
bind ica_top ica_assertions i_chk (.*);

// ==== verif/ica_pulse_src.sv ====
`timescale 1ns/1ps
module ica_pulse_src (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Waveform in clock cycles
  input wire logic i_run,
  input wire logic [15:0] i_high,
  input wire logic [15:0] i_low,
  // Pulse line
  output logic o_pulse
);
  logic [15:0] cnt_ff;
  // Rectangular train, line off while stopped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_run) begin
      cnt_ff <= 16'h0;
      o_pulse <= 1'b0;
    end else if (cnt_ff <= 16'h1) begin
      o_pulse <= !o_pulse;
      cnt_ff <= o_pulse ? i_low : i_high;
    end else begin
      cnt_ff <= cnt_ff - 16'h1;
    end
  end
endmodule // ica_pulse_src

// ==== verif/input_capture_and_interrupt_tb_top.sv ====
`timescale 1ns/1ps
module input_capture_and_interrupt_tb_top;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, run = 1'b0, pulse;
  logic [11:0] din = 12'h0, i_din;
  logic i_meas_en_stb = 1'b0, i_cnt_def_stb = 1'b0, i_sysopt_stb = 1'b0, i_intr_def_stb = 1'b0;
  logic [2:0] i_meas_en_ch = 3'h0, i_query_ch = 3'h0;
  logic [1:0] i_cnt_def_pair = 2'h0, i_query_kind = 2'h0;
  logic [7:0] i_sysopt_num = 8'h0, i_sysopt_val = 8'h0;
  logic [4:0] i_intr_def_src = 5'h0, o_svc_src;
  logic [15:0] i_intr_def_period_ms = 16'h0;
  logic i_intr_def_falling = 1'b0, i_svc_done = 1'b0, i_query_stb = 1'b0;
  logic o_svc_start, o_svc_active, o_query_busy, o_query_valid, o_periodic_en, o_tenth_mode;
  logic [31:0] o_query_data, qd, per;
  logic [5:0] o_meas_en;
  logic [2:0] o_cnt_en;
  logic [11:0] o_intr_en;
  int failures = 0, checks_done = 0;
  time t0;
  // Partner drives inputs 1 and 5
  assign i_din = din | {7'h0, pulse, 3'h0, pulse};
  always #5 i_clk = ~i_clk;
  ica_pulse_src i_src (.i_clk, .i_sys_rst, .i_run(run), .i_high(16'h01f4), .i_low(16'h02bc), .o_pulse(pulse));
  ica_top #(.P_MS_CYCLES(20)) i_dut (.i_clk, .i_sys_rst, .i_din, .i_meas_en_stb, .i_meas_en_ch, .i_cnt_def_stb,
    .i_cnt_def_pair, .i_sysopt_stb, .i_sysopt_num, .i_sysopt_val, .i_intr_def_stb, .i_intr_def_src,
    .i_intr_def_falling, .i_intr_def_period_ms, .i_svc_done, .o_svc_start, .o_svc_src, .o_svc_active,
    .i_query_stb, .i_query_ch, .i_query_kind, .o_query_busy, .o_query_valid, .o_query_data, .o_meas_en,
    .o_cnt_en, .o_intr_en, .o_periodic_en, .o_tenth_mode);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Strobes: meas, counter, option, interrupt
  task automatic cmd(input logic [3:0] s, input logic [4:0] a, input logic f, input logic [15:0] p);
    @(posedge i_clk);
    {i_meas_en_stb, i_cnt_def_stb, i_sysopt_stb, i_intr_def_stb} <= s;
    i_meas_en_ch <= a[2:0];
    i_cnt_def_pair <= a[1:0];
    i_sysopt_num <= ica_pkg::OPT_TENTH_US;
    i_sysopt_val <= {7'h0, f};
    i_intr_def_src <= a;
    i_intr_def_falling <= f;
    i_intr_def_period_ms <= p;
    @(posedge i_clk);
    {i_meas_en_stb, i_cnt_def_stb, i_sysopt_stb, i_intr_def_stb} <= 4'h0;
    @(negedge i_clk);
  endtask
  // Query, result left in qd
  task automatic q(input logic [2:0] c, input logic [1:0] k);
    @(posedge i_clk);
    i_query_stb <= 1'b1;
    i_query_ch <= c;
    i_query_kind <= k;
    @(posedge i_clk);
    i_query_stb <= 1'b0;
    for (int n = 0; n < 40 && o_query_valid !== 1'b1; n++) @(negedge i_clk);
    qd = o_query_data;
  endtask
  task automatic rng(input string n, input logic [31:0] e);
    chk(n, 32'(qd >= e - 32'h1 && qd <= e + 32'h1), 32'h1);
  endtask
  task automatic wait_start(input logic [4:0] s);
    for (int n = 0; n < 60 && o_svc_start !== 1'b1; n++) @(negedge i_clk);
    chk("svc_start", 32'(o_svc_start), 32'h1);
    chk("svc_src", 32'(o_svc_src), 32'(s));
  endtask
  task automatic done;
    @(posedge i_clk);
    i_svc_done <= 1'b1;
    @(posedge i_clk);
    i_svc_done <= 1'b0;
  endtask
  // Reset state of measurement enables and unit mode
  task automatic t_reset;
    chk("meas_en", 32'(o_meas_en), 32'h0);
    chk("tenth", 32'(o_tenth_mode), 32'h0);
  endtask
  // Pin ownership commands
  task automatic t_own;
    cmd(4'h8, 5'h1, 1'b0, 16'h0);
    chk("meas_en", 32'(o_meas_en), 32'h01);
    cmd(4'h4, 5'h1, 1'b0, 16'h0);
    chk("cnt_en", 32'(o_cnt_en), 32'h2);
    chk("meas_en", 32'(o_meas_en), 32'h0d);
    cmd(4'h8, 5'h3, 1'b0, 16'h0);
    chk("cnt_en", 32'(o_cnt_en), 32'h0);
    cmd(4'h1, 5'h3, 1'b0, 16'h0);
    chk("meas_en", 32'(o_meas_en), 32'h09);
    cmd(4'h1, 5'h9, 1'b0, 16'h0);
    cmd(4'h1, 5'ha, 1'b1, 16'h0);
    cmd(4'h1, 5'h7, 1'b0, 16'h0);
    chk("intr_en", 32'(o_intr_en), 32'h304);
  endtask
  // Width, period, frequency in both unit modes
  task automatic t_meas;
    cmd(4'h4, 5'h0, 1'b0, 16'h0);
    cmd(4'h8, 5'h5, 1'b0, 16'h0);
    chk("cnt_en", 32'(o_cnt_en), 32'h1);
    run <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      repeat (6000) @(posedge i_clk);
      q(3'h1, ica_pkg::KIND_WIDTH);
      rng("width1", m ? 32'd50 : 32'd5);
      q(3'h1, ica_pkg::KIND_PERIOD);
      rng("period1", m ? 32'd120 : 32'd12);
      per = qd;
      q(3'h1, ica_pkg::KIND_FREQ);
      chk("freq1", qd, (m ? ica_pkg::UNITS_PER_S_TENTH : ica_pkg::UNITS_PER_S_US) / per);
      q(3'h5, ica_pkg::KIND_WIDTH);
      rng("width5", 32'd5);
      cmd(4'h2, 5'h0, 1'b1, 16'h0);
      chk("tenth", 32'(o_tenth_mode), 32'h1);
    end
    run <= 1'b0;
    repeat (3000) @(posedge i_clk);
    q(3'h1, ica_pkg::KIND_WIDTH);
    rng("width_hold", 32'd50);
    cmd(4'h2, 5'h0, 1'b0, 16'h0);
    chk("tenth", 32'(o_tenth_mode), 32'h0);
  endtask
  // Edges, polarity, priority, periodic timer
  task automatic t_intr;
    @(posedge i_clk);
    din[2] <= 1'b1;
    @(posedge i_clk);
    din[2] <= 1'b0;
    wait_start(5'h3);
    done();
    din[9] <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk("active", 32'(o_svc_active), 32'h0);
    din[9] <= 1'b0;
    wait_start(5'ha);
    done();
    @(posedge i_clk);
    din <= 12'h104;
    wait_start(5'h3);
    done();
    wait_start(5'h9);
    done();
    din <= 12'h0;
    cmd(4'h1, 5'h12, 1'b0, 16'h2);
    chk("periodic", 32'(o_periodic_en), 32'h1);
    wait_start(5'h12);
    t0 = $time;
    done();
    wait_start(5'h12);
    chk("tick_gap", 32'(($time - t0) / 10), 32'd40);
    @(posedge i_clk);
    din[2] <= 1'b1;
    repeat (100) @(posedge i_clk);
    din[2] <= 1'b0;
    done();
    wait_start(5'h12);
    cmd(4'h1, 5'h12, 1'b0, 16'h0);
    done();
    wait_start(5'h3);
    done();
    for (int s = 1; s <= 12; s++) cmd(4'h1, 5'(s), 1'b0, 16'h0);
    chk("intr_en", 32'(o_intr_en), 32'hf3f);
    chk("meas_en", 32'(o_meas_en), 32'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    t_reset();
    t_own();
    t_meas();
    t_intr();
    print_verdict();
  end
endmodule // input_capture_and_interrupt_tb_top
